/* include/remote_handshake_map.vh */
// Constants for the remote-register handshake block: answer codes,
// instruction code ranges, sign words and input-source defaults.
// Assumes a single 25 MHz clock domain; included by the design files only.
`ifndef REMOTE_HANDSHAKE_MAP_VH
`define REMOTE_HANDSHAKE_MAP_VH

`define ANS_NORMAL 4'h0
`define ANS_CODE_ERR 4'h1
`define ANS_SELECT_ERR 4'h2
`define ANS_RANGE_ERR 4'h3

`define ANS_MON_LSB 0
`define ANS_INS_LSB 4

`define READ_CODE_MIN 16'h0000
`define READ_CODE_MAX 16'h0a1f
`define WRITE_CODE_MIN 16'h8000
`define WRITE_CODE_MAX 16'h911f
`define POINT_GROUP_MIN 8'h8b
`define POINT_LAST_BAD 8'hff

`define SIGN_POS 16'h0000
`define SIGN_NEG 16'hffff

`define ITEM_OK 2'h0
`define ITEM_BAD_CODE 2'h1
`define ITEM_NOT_ENABLED 2'h2
`define ITEM_OUT_OF_RANGE 2'h3

`define SRC_SELECT_RESET 5'h07
`define SRC_WIDTH 5

`endif

/* rtl/input_sync3.v */
// Three-stage synchroniser for connector input pins.
// Assumes the pins are asynchronous to MCLK; output moves only when stages agree.
`timescale 1ns/1ps
`include "remote_handshake_map.vh"

module input_sync3 (
    input wire clk,
    input wire rst_n,
    input wire [`SRC_WIDTH-1:0] pin_in,
    output reg [`SRC_WIDTH-1:0] level_q
);
    reg [`SRC_WIDTH-1:0] s1_q;
    reg [`SRC_WIDTH-1:0] s2_q;
    reg [`SRC_WIDTH-1:0] s3_q;
    integer i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= {`SRC_WIDTH{1'b0}};
            s2_q <= {`SRC_WIDTH{1'b0}};
            s3_q <= {`SRC_WIDTH{1'b0}};
            level_q <= {`SRC_WIDTH{1'b0}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Per bit, a change counts only once two stages agree
            for (i = 0; i < `SRC_WIDTH; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // input_sync3

/* rtl/servo_remote_register_handshake.v */
// Remote-register handshake: monitor reads, instruction-code read/write
// sequences, answer-code reporting and per-signal input source selection.
// Assumes network words/bits arrive from logic on MCLK; the item store
// (parameters, point tables) and monitor sources sit outside this block.
`timescale 1ns/1ps
`include "remote_handshake_map.vh"

module servo_remote_register_handshake (
    input wire MCLK,
    input wire NRST,
    input wire TWO_STATIONS,
    input wire [15:0] MONITOR_SELECT_A,
    input wire [15:0] MONITOR_SELECT_B,
    input wire MONITOR_REQUEST,
    output reg MONITORING_ACK,
    output reg [15:0] MONITOR_RESULT_W0,
    output reg [15:0] MONITOR_RESULT_W1,
    output reg [15:0] MONITOR_RESULT_W5,
    output reg [15:0] MONITOR_RESULT_W6,
    output wire [15:0] MON_CODE_A,
    output wire [15:0] MON_CODE_B,
    input wire [31:0] MON_DATA_A,
    input wire [31:0] MON_DATA_B,
    input wire MON_SUPPORTED_A,
    input wire MON_SUPPORTED_B,
    input wire MON_WIDE_A,
    input wire MON_WIDE_B,
    input wire [15:0] INSTRUCTION_CODE_WORD,
    input wire [15:0] WRITE_VALUE_WORD,
    input wire INSTRUCTION_REQUEST,
    output reg INSTRUCTION_DONE,
    output reg [15:0] READ_VALUE_WORD,
    output wire [15:0] ANSWER_WORD,
    output reg [15:0] ITEM_CODE,
    output reg [15:0] ITEM_WRITE_DATA,
    output reg ITEM_READ_STROBE,
    output reg ITEM_WRITE_STROBE,
    input wire [15:0] ITEM_READ_DATA,
    input wire ITEM_ACK,
    input wire [1:0] ITEM_STATUS,
    input wire SOURCE_SELECT_LOAD,
    input wire [`SRC_WIDTH-1:0] SOURCE_SELECT_DATA,
    output reg [`SRC_WIDTH-1:0] SOURCE_SELECT,
    input wire [`SRC_WIDTH-1:0] NETWORK_INPUTS,
    input wire [`SRC_WIDTH-1:0] CONNECTOR_INPUTS,
    output reg [`SRC_WIDTH-1:0] EFFECTIVE_INPUTS
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_BUSY = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;

    reg rst_a_q;
    reg rst_n_q;
    reg [1:0] ins_state_q;
    reg [1:0] ins_state_d;
    reg [3:0] mon_err_q;
    reg [3:0] ins_err_q;
    reg [3:0] ins_err_d;
    reg ins_is_read_q;
    reg ins_is_read_d;
    reg done_d;
    reg rd_strobe_d;
    reg wr_strobe_d;
    reg [15:0] read_value_d;
    reg [15:0] item_code_d;
    reg [15:0] item_wdata_d;
    wire [`SRC_WIDTH-1:0] conn_level;
    wire code_is_read;
    wire code_is_write;
    wire code_bad_table;

    // Upper result word: real upper half, or sign word when value is 16-bit
    function [15:0] upper_word;
        input [31:0] value;
        input wide;
        begin
            if (wide) begin
                upper_word = value[31:16];
            end else if (value[15]) begin
                upper_word = `SIGN_NEG;
            end else begin
                upper_word = `SIGN_POS;
            end
        end
    endfunction

    // Map item store status onto an answer digit
    function [3:0] status_code;
        input [1:0] status;
        begin
            case (status)
                `ITEM_BAD_CODE: status_code = `ANS_CODE_ERR;
                `ITEM_NOT_ENABLED: status_code = `ANS_SELECT_ERR;
                `ITEM_OUT_OF_RANGE: status_code = `ANS_RANGE_ERR;
                default: status_code = `ANS_NORMAL;
            endcase
        end
    endfunction

    // Reset released through two flops so every register leaves reset together
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rst_a_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n_q <= rst_a_q;
        end
    end

    input_sync3 conn_sync (
        .clk(MCLK),
        .rst_n(rst_n_q),
        .pin_in(CONNECTOR_INPUTS),
        .level_q(conn_level)
    );

    // Input source selection
    always @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            SOURCE_SELECT <= `SRC_SELECT_RESET;
            EFFECTIVE_INPUTS <= {`SRC_WIDTH{1'b0}};
        end else begin
            if (SOURCE_SELECT_LOAD) begin
                SOURCE_SELECT <= SOURCE_SELECT_DATA;
            end
            // Network copy of a connector-sourced signal is simply dropped
            EFFECTIVE_INPUTS <= (SOURCE_SELECT & conn_level)
                | (~SOURCE_SELECT & NETWORK_INPUTS);
        end
    end

    // Monitor path: the source sees the live selection words
    assign MON_CODE_A = MONITOR_SELECT_A;
    assign MON_CODE_B = MONITOR_SELECT_B;

    always @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            MONITORING_ACK <= 1'b0;
            MONITOR_RESULT_W0 <= 16'h0000;
            MONITOR_RESULT_W1 <= 16'h0000;
            MONITOR_RESULT_W5 <= 16'h0000;
            MONITOR_RESULT_W6 <= 16'h0000;
            mon_err_q <= `ANS_NORMAL;
        end else begin
            // Ack tracks request so it falls once the master drops it
            MONITORING_ACK <= MONITOR_REQUEST;
            if (MONITOR_REQUEST) begin
                // Loaded every cycle while requested; ack rises on the same edge
                MONITOR_RESULT_W0 <= MON_DATA_A[15:0];
                if (TWO_STATIONS) begin
                    MONITOR_RESULT_W1 <= upper_word(MON_DATA_A, MON_WIDE_A);
                    MONITOR_RESULT_W5 <= MON_DATA_B[15:0];
                    MONITOR_RESULT_W6 <= upper_word(MON_DATA_B, MON_WIDE_B);
                end else begin
                    // Word 1 carries the second selection, e.g. the upper code
                    MONITOR_RESULT_W1 <= MON_DATA_B[15:0];
                end
                if (!MON_SUPPORTED_A || !MON_SUPPORTED_B) begin
                    mon_err_q <= `ANS_CODE_ERR;
                end else begin
                    mon_err_q <= `ANS_NORMAL;
                end
            end
            // With the request low nothing is loaded, so all words hold
        end
    end

    // Instruction code classification
    assign code_is_read = (INSTRUCTION_CODE_WORD >= `READ_CODE_MIN)
        && (INSTRUCTION_CODE_WORD <= `READ_CODE_MAX);
    assign code_is_write = (INSTRUCTION_CODE_WORD >= `WRITE_CODE_MIN)
        && (INSTRUCTION_CODE_WORD <= `WRITE_CODE_MAX);
    // Point table groups index the table by the low byte; 255 is not usable
    assign code_bad_table = code_is_write
        && (INSTRUCTION_CODE_WORD[15:8] >= `POINT_GROUP_MIN)
        && (INSTRUCTION_CODE_WORD[7:0] == `POINT_LAST_BAD);

    always @* begin
        ins_state_d = ins_state_q;
        ins_err_d = ins_err_q;
        ins_is_read_d = ins_is_read_q;
        done_d = INSTRUCTION_DONE;
        rd_strobe_d = 1'b0;
        wr_strobe_d = 1'b0;
        read_value_d = READ_VALUE_WORD;
        item_code_d = ITEM_CODE;
        item_wdata_d = ITEM_WRITE_DATA;
        case (ins_state_q)
            ST_IDLE: begin
                if (INSTRUCTION_REQUEST) begin
                    item_code_d = INSTRUCTION_CODE_WORD;
                    item_wdata_d = WRITE_VALUE_WORD;
                    ins_is_read_d = code_is_read;
                    if (code_bad_table || (!code_is_read && !code_is_write)) begin
                        // Refused codes still complete so the master is not stuck
                        ins_err_d = `ANS_CODE_ERR;
                        done_d = 1'b1;
                        ins_state_d = ST_DONE;
                    end else begin
                        rd_strobe_d = code_is_read;
                        wr_strobe_d = code_is_write;
                        ins_state_d = ST_BUSY;
                    end
                end
            end
            ST_BUSY: begin
                if (ITEM_ACK) begin
                    // Read data and done are published on one edge; a refused
                    // read leaves the last good value standing for the master
                    if (ins_is_read_q && (ITEM_STATUS == `ITEM_OK)) begin
                        read_value_d = ITEM_READ_DATA;
                    end
                    ins_err_d = status_code(ITEM_STATUS);
                    done_d = 1'b1;
                    ins_state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!INSTRUCTION_REQUEST) begin
                    done_d = 1'b0;
                    ins_state_d = ST_IDLE;
                end
            end
            default: begin
                done_d = 1'b0;
                ins_state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ins_state_q <= ST_IDLE;
            ins_err_q <= `ANS_NORMAL;
            ins_is_read_q <= 1'b0;
            INSTRUCTION_DONE <= 1'b0;
            ITEM_READ_STROBE <= 1'b0;
            ITEM_WRITE_STROBE <= 1'b0;
            READ_VALUE_WORD <= 16'h0000;
            ITEM_CODE <= 16'h0000;
            ITEM_WRITE_DATA <= 16'h0000;
        end else begin
            ins_state_q <= ins_state_d;
            ins_err_q <= ins_err_d;
            ins_is_read_q <= ins_is_read_d;
            INSTRUCTION_DONE <= done_d;
            ITEM_READ_STROBE <= rd_strobe_d;
            ITEM_WRITE_STROBE <= wr_strobe_d;
            READ_VALUE_WORD <= read_value_d;
            ITEM_CODE <= item_code_d;
            ITEM_WRITE_DATA <= item_wdata_d;
        end
    end

    // Monitor errors in the lowest digit, instruction errors in the next
    assign ANSWER_WORD = {8'h00, ins_err_q, mon_err_q};

endmodule // servo_remote_register_handshake

/* tb/handshake_sva.sv */
// Assertion checker for the remote handshake block, bound to its top ports.
// Assumes the single MCLK domain with NRST as its only reset.
`timescale 1ns/1ps
module handshake_sva (
    input wire MCLK,
    input wire NRST,
    input wire MONITOR_REQUEST,
    input wire MONITORING_ACK,
    input wire [15:0] MONITOR_RESULT_W0,
    input wire [15:0] MONITOR_RESULT_W1,
    input wire [31:0] MON_DATA_A,
    input wire MON_SUPPORTED_A,
    input wire MON_SUPPORTED_B,
    input wire INSTRUCTION_REQUEST,
    input wire INSTRUCTION_DONE,
    input wire [15:0] READ_VALUE_WORD,
    input wire [15:0] ANSWER_WORD,
    input wire ITEM_ACK,
    input wire SOURCE_SELECT_LOAD,
    input wire [4:0] SOURCE_SELECT_DATA,
    input wire [4:0] SOURCE_SELECT,
    input wire [4:0] NETWORK_INPUTS,
    input wire [4:0] EFFECTIVE_INPUTS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    property p_ack_rise; MONITOR_REQUEST |=> MONITORING_ACK; endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("ack late");
    property p_ack_fall; !MONITOR_REQUEST |=> !MONITORING_ACK; endproperty
    a_ack_fall: assert property (p_ack_fall) else $error("ack stuck");
    property p_freeze; !MONITOR_REQUEST |=> $stable(MONITOR_RESULT_W0)
        && $stable(MONITOR_RESULT_W1); endproperty
    a_freeze: assert property (p_freeze) else $error("words moved");
    property p_low; MONITOR_REQUEST && MON_SUPPORTED_A |=>
        MONITOR_RESULT_W0 == $past(MON_DATA_A[15:0]); endproperty
    a_low: assert property (p_low) else $error("word 0 stale");
    property p_mon_err; MONITOR_REQUEST |=> ANSWER_WORD[3:0] ==
        ($past(MON_SUPPORTED_A && MON_SUPPORTED_B) ? 4'h0 : 4'h1); endproperty
    a_mon_err: assert property (p_mon_err) else $error("monitor digit");
    property p_done_fall; !INSTRUCTION_REQUEST |=> !INSTRUCTION_DONE; endproperty
    a_done_fall: assert property (p_done_fall) else $error("done stuck");
    property p_rv_hold; !ITEM_ACK |=> $stable(READ_VALUE_WORD); endproperty
    a_rv_hold: assert property (p_rv_hold) else $error("read value moved");
    property p_src; SOURCE_SELECT_LOAD |=> SOURCE_SELECT == $past(SOURCE_SELECT_DATA);
    endproperty
    a_src: assert property (p_src) else $error("source load");
    property p_net; 1'b1 |=> (EFFECTIVE_INPUTS & ~$past(SOURCE_SELECT)) ==
        ($past(NETWORK_INPUTS) & ~$past(SOURCE_SELECT)); endproperty
    a_net: assert property (p_net) else $error("network input");
    c_mon: cover property (MONITOR_REQUEST && !MON_SUPPORTED_B);
    c_range: cover property (INSTRUCTION_DONE && ANSWER_WORD[7:4] == 4'h3);
    c_load: cover property (SOURCE_SELECT_LOAD);
endmodule // handshake_sva
bind servo_remote_register_handshake handshake_sva chk_i (.*);

/* tb/item_store.sv */
// Item store model: answers item strobes after a short or a long wait.
// Assumes one-cycle strobes and ITEM_CODE steady until the ack.
`timescale 1ns/1ps
module item_store (
    input wire MCLK,
    input wire ITEM_SLOW,
    input wire [15:0] ITEM_CODE,
    input wire [15:0] ITEM_WRITE_DATA,
    input wire ITEM_READ_STROBE,
    input wire ITEM_WRITE_STROBE,
    output logic [15:0] ITEM_READ_DATA,
    output logic ITEM_ACK,
    output logic [1:0] ITEM_STATUS
);
    logic busy = 1'b0;
    logic [2:0] wait_q = 3'h0;
    initial begin
        ITEM_READ_DATA = 16'h0;
        ITEM_ACK = 1'b0;
    end
    always @(posedge MCLK) begin
        ITEM_ACK <= 1'b0;
        ITEM_STATUS <= 2'h0;
        // Data means nothing outside the ack cycle, so it churns there
        ITEM_READ_DATA <= ~ITEM_READ_DATA;
        if (ITEM_READ_STROBE || ITEM_WRITE_STROBE) begin
            busy <= 1'b1;
            wait_q <= ITEM_SLOW ? 3'h4 : 3'h0;
        end else if (busy && wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end else if (busy) begin
            busy <= 1'b0;
            ITEM_ACK <= 1'b1;
            ITEM_READ_DATA <= ITEM_CODE ^ 16'h5a5a;
            if (ITEM_CODE[7:0] == 8'hee) ITEM_STATUS <= 2'h2;
            else if (ITEM_CODE[15] && ITEM_WRITE_DATA == 16'hffff) ITEM_STATUS <= 2'h3;
        end
    end
endmodule // item_store

/* tb/testbench.sv */
// Self-checking bench: monitor, instruction and input-source traffic.
// Assumes the design, the item store model and the checker are compiled.
`timescale 1ns/1ps
module testbench;
    logic MCLK = 1'b0, NRST = 1'b0, TWO_STATIONS = 1'b0, MONITOR_REQUEST = 1'b0;
    logic INSTRUCTION_REQUEST = 1'b0, SOURCE_SELECT_LOAD = 1'b0, ITEM_SLOW = 1'b0;
    logic [15:0] MONITOR_SELECT_A = 16'h0, MONITOR_SELECT_B = 16'h0;
    logic [15:0] INSTRUCTION_CODE_WORD = 16'h0, WRITE_VALUE_WORD = 16'h0;
    logic [4:0] SOURCE_SELECT_DATA = 5'h0, NETWORK_INPUTS = 5'h0, CONNECTOR_INPUTS = 5'h0;
    logic MONITORING_ACK, MON_SUPPORTED_A, MON_SUPPORTED_B, MON_WIDE_A, MON_WIDE_B;
    logic INSTRUCTION_DONE, ITEM_READ_STROBE, ITEM_WRITE_STROBE, ITEM_ACK;
    logic [15:0] MONITOR_RESULT_W0, MONITOR_RESULT_W1, MONITOR_RESULT_W5, MONITOR_RESULT_W6;
    logic [15:0] MON_CODE_A, MON_CODE_B, READ_VALUE_WORD, ANSWER_WORD, ITEM_CODE;
    logic [15:0] ITEM_WRITE_DATA, ITEM_READ_DATA, exp_rv, a, b;
    logic [31:0] MON_DATA_A, MON_DATA_B;
    logic [1:0] ITEM_STATUS;
    logic [4:0] SOURCE_SELECT, EFFECTIVE_INPUTS;
    logic [15:0] corner [9] = '{16'h0000, 16'h0a1f, 16'h0a20, 16'h7fff, 16'h911f,
        16'h9120, 16'h8cff, 16'h01ee, 16'h8001};
    int err_count = 0, check_count = 0, i, n;
    servo_remote_register_handshake DUT (.*);
    item_store store (.*);
    // Odd codes carry a real upper half; codes Fxxx are unsupported
    function automatic logic [15:0] hi(input logic [15:0] c);
        return c[0] ? ~c : {16{c[15]}};
    endfunction
    assign MON_DATA_A = {hi(MON_CODE_A), MON_CODE_A};
    assign MON_DATA_B = {hi(MON_CODE_B), MON_CODE_B};
    assign MON_WIDE_A = MON_CODE_A[0];
    assign MON_WIDE_B = MON_CODE_B[0];
    assign MON_SUPPORTED_A = MON_CODE_A[15:12] != 4'hf;
    assign MON_SUPPORTED_B = MON_CODE_B[15:12] != 4'hf;
    function automatic logic [3:0] ins_err(input logic [15:0] c, w);
        if (c > 16'h0a1f && (c < 16'h8000 || c > 16'h911f)) return 4'h1;
        if (c >= 16'h8b00 && c[7:0] == 8'hff) return 4'h1;
        if (c[7:0] == 8'hee) return 4'h2;
        if (c[15] && w == 16'hffff) return 4'h3;
        return 4'h0;
    endfunction
    task automatic chk(input string nm, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wait_done(input logic v);
        for (i = 0; i < 40 && INSTRUCTION_DONE !== v; i++) begin
            @(posedge MCLK);
            #1;
        end
        if (INSTRUCTION_DONE !== v) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    task automatic instr(input logic [15:0] c, w);
        logic [3:0] e;
        e = ins_err(c, w);
        @(posedge MCLK);
        INSTRUCTION_CODE_WORD <= c;
        WRITE_VALUE_WORD <= w;
        ITEM_SLOW <= 1'($urandom);
        @(posedge MCLK);
        INSTRUCTION_REQUEST <= 1'b1;
        wait_done(1'b1);
        if (!c[15] && e == 4'h0) exp_rv = c ^ 16'h5a5a;
        chk("answer", ANSWER_WORD & 16'hfff0, {8'h0, e, 4'h0});
        chk("read value", READ_VALUE_WORD, exp_rv);
        @(posedge MCLK);
        INSTRUCTION_REQUEST <= 1'b0;
        wait_done(1'b0);
    endtask
    task automatic mon(input logic two);
        a = 16'($urandom);
        b = 16'($urandom);
        @(posedge MCLK);
        MONITOR_SELECT_A <= a;
        MONITOR_SELECT_B <= b;
        TWO_STATIONS <= two;
        @(posedge MCLK);
        MONITOR_REQUEST <= 1'b1;
        repeat (2) @(posedge MCLK);
        a = a ^ 16'h0002;
        MONITOR_SELECT_A <= a;
        repeat (2) @(posedge MCLK);
        #1;
        chk("ack", 16'(MONITORING_ACK), 16'h1);
        chk("mon answer", ANSWER_WORD & 16'hff0f,
            {15'h0, a[15:12] == 4'hf || b[15:12] == 4'hf});
        if (a[15:12] != 4'hf && b[15:12] != 4'hf) begin
            chk("w0", MONITOR_RESULT_W0, a);
            chk("w1", MONITOR_RESULT_W1, two ? hi(a) : b);
            if (two) chk("w5", MONITOR_RESULT_W5, b);
            if (two) chk("w6", MONITOR_RESULT_W6, hi(b));
        end
        @(posedge MCLK);
        MONITOR_REQUEST <= 1'b0;
        MONITOR_SELECT_A <= ~a;
        repeat (3) @(posedge MCLK);
        #1;
        chk("ack off", 16'(MONITORING_ACK), 16'h0);
        if (a[15:12] != 4'hf && b[15:12] != 4'hf) chk("w0 held", MONITOR_RESULT_W0, a);
    endtask
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    initial begin
        void'($urandom(32'h02aa));
        exp_rv = 16'h0;
        repeat (5) @(posedge MCLK);
        NRST <= 1'b1;
        repeat (3) @(posedge MCLK);
        #1;
        chk("source reset", 16'(SOURCE_SELECT), 16'h0007);
        for (n = 0; n < 12; n++) mon(n[0]);
        for (n = 0; n < 9; n++) instr(corner[n], n == 8 ? 16'hffff : 16'h1234);
        for (n = 0; n < 20; n++) instr(n[0] ? 16'h8000 + 16'($urandom_range(0, 4383))
            : 16'($urandom_range(0, 2591)), 16'($urandom));
        repeat (6) begin
            @(posedge MCLK);
            SOURCE_SELECT_LOAD <= 1'b1;
            SOURCE_SELECT_DATA <= 5'($urandom);
            NETWORK_INPUTS <= 5'($urandom);
            CONNECTOR_INPUTS <= 5'($urandom);
            @(posedge MCLK);
            SOURCE_SELECT_LOAD <= 1'b0;
            repeat (8) @(posedge MCLK);
            #1;
            chk("inputs", 16'(EFFECTIVE_INPUTS), 16'((SOURCE_SELECT_DATA & CONNECTOR_INPUTS)
                | (~SOURCE_SELECT_DATA & NETWORK_INPUTS)));
        end
        tally_and_finish();
    end
endmodule // testbench
